// >>> rtl/ipvc_ctrl.sv
// Priority level registers, vector base and fast interrupt vectoring with APB access
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "ipvc_params.svh"

module ipvc_ctrl
   import ipvc_pkg::*;
#(
   parameter logic [13:0] VBASE_RESET = `IPVC_VBASE_RST_DEFAULT,
   parameter int ADDR_W = 8
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [NUM_REQ-1:0] REQ_I,
   output logic IRQ_O,
   output logic FAST_O,
   output logic [1:0] LEVEL_O,
   output logic [5:0] VEC_NUM_O,
   output logic [20:0] VECTOR_ADDR_O
);

   // ****************************************************************
   // Register storage
   // ****************************************************************
   ipvc_word_t tmr_cmp_reg;
   ipvc_word_t pwm_adc_reg;
   logic [13:0] vbase_reg;
   logic [5:0] fim_reg [2];
   ipvc_word_t fival_reg [2];
   logic [4:0] fivah_reg [2];
   logic [31:0] prdata_reg;
   ipvc_vec_s out_reg;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire logic [ADDR_W-3:0] word_idx = PADDR_I[ADDR_W-1:2];
   wire logic aligned = (PADDR_I[1:0] == 2'h0);
   wire logic hit_tmr = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_TMR_CMP));
   wire logic hit_pwm = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_PWM_ADC));
   wire logic hit_vba = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_VBASE));
   wire logic hit_fast_irq0_match = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_FAST_IRQ0_MATCH));
   wire logic hit_fvl0 = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_FAST_IRQ0_ADDR_LOW));
   wire logic hit_fvh0 = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_FAST_IRQ0_ADDR_HIGH));
   wire logic hit_fim1 = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_FIM1));
   wire logic hit_fvl1 = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_FIVAL1));
   wire logic hit_fvh1 = aligned && (word_idx == (ADDR_W-2)'(`IPVC_IDX_FIVAH1));
   wire logic hit_any = hit_tmr | hit_pwm | hit_vba | hit_fast_irq0_match | hit_fvl0 | hit_fvh0
                        | hit_fim1 | hit_fvl1 | hit_fvh1;
   wire logic setup = PSEL_I && !PENABLE_I;
   wire logic access = PSEL_I && PENABLE_I;
   wire logic wr = access && PWRITE_I && hit_any;
   wire ipvc_word_t wdata = PWDATA_I[15:0];

   // Zero wait states: read data is captured in the setup cycle
   assign PREADY_O = 1'b1;
   // Unmapped or misaligned words answer with an error and change nothing
   assign PSLVERR_O = access && !hit_any;

   wire ipvc_word_t rd_word =
      hit_tmr  ? (tmr_cmp_reg & `IPVC_MASK_TMR_CMP) :
      hit_pwm  ? (pwm_adc_reg & `IPVC_MASK_PWM_ADC) :
      hit_vba  ? {2'h0, vbase_reg} :
      hit_fast_irq0_match ? {10'h000, fim_reg[0]} :
      hit_fvl0 ? fival_reg[0] :
      hit_fvh0 ? {11'h000, fivah_reg[0]} :
      hit_fim1 ? {10'h000, fim_reg[1]} :
      hit_fvl1 ? fival_reg[1] :
      hit_fvh1 ? {11'h000, fivah_reg[1]} : 16'h0000;

   wire logic [31:0] prdata_next = setup ? {16'h0000, rd_word} : prdata_reg;
   assign PRDATA_O = prdata_reg;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   // priority fields come out of reset disabled
   // vector base reset value follows the variant parameter
   // written at the access edge, used by arbitration next cycle
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tmr_cmp_reg <= `IPVC_RST_LEVELS;
         pwm_adc_reg <= `IPVC_RST_LEVELS;
         vbase_reg <= VBASE_RESET;
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
         if (wr && hit_tmr) begin
            tmr_cmp_reg <= wdata & `IPVC_MASK_TMR_CMP;
         end
         if (wr && hit_pwm) begin
            pwm_adc_reg <= wdata & `IPVC_MASK_PWM_ADC;
         end
         if (wr && hit_vba) begin
            vbase_reg <= wdata[13:0];
         end
      end
   end

   wire logic [1:0] wr_fim = {wr && hit_fim1, wr && hit_fast_irq0_match};
   wire logic [1:0] wr_fvl = {wr && hit_fvl1, wr && hit_fvl0};
   wire logic [1:0] wr_fvh = {wr && hit_fvh1, wr && hit_fvh0};

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int k = 0; k < 2; k++) begin
            fim_reg[k] <= 6'h00;
            fival_reg[k] <= `IPVC_RST_FIVA;
            fivah_reg[k] <= 5'h00;
         end
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (wr_fim[k]) begin
               fim_reg[k] <= wdata[5:0];
            end
            // 16-bit low and 5-bit high halves
            if (wr_fvl[k]) begin
               fival_reg[k] <= wdata;
            end
            if (wr_fvh[k]) begin
               fivah_reg[k] <= wdata[4:0];
            end
         end
      end
   end

   // ****************************************************************
   // Level fields, one per request, in request index order
   // ****************************************************************
   // second timer channels 0..3
   wire logic [1:0] timer2_ch0_level = tmr_cmp_reg[`IPVC_LSB_T2C0 +: 2];
   wire logic [1:0] timer2_ch1_level = tmr_cmp_reg[`IPVC_LSB_T2C1 +: 2];
   wire logic [1:0] timer2_ch2_level = tmr_cmp_reg[`IPVC_LSB_T2C2 +: 2];
   wire logic [1:0] timer2_ch3_level = tmr_cmp_reg[`IPVC_LSB_T2C3 +: 2];
   wire logic [1:0] comparator_a_level = tmr_cmp_reg[`IPVC_LSB_CMPA +: 2];
   wire logic [1:0] comparator_b_level = tmr_cmp_reg[`IPVC_LSB_CMPB +: 2];
   wire logic [1:0] interval_timer0_level = tmr_cmp_reg[`IPVC_LSB_PIT0 +: 2];
   wire logic [1:0] interval_timer2_level = pwm_adc_reg[`IPVC_LSB_PIT2 +: 2];
   wire logic [1:0] adc_a_done_level = pwm_adc_reg[`IPVC_LSB_ADAD +: 2];
   wire logic [1:0] adc_b_done_level = pwm_adc_reg[`IPVC_LSB_ADBD +: 2];
   wire logic [1:0] adc_zero_cross_level = pwm_adc_reg[`IPVC_LSB_ADZC +: 2];
   wire logic [1:0] pwm_reload_level = pwm_adc_reg[`IPVC_LSB_PWMR +: 2];
   wire logic [1:0] pwm_fault_level = pwm_adc_reg[`IPVC_LSB_PWMF +: 2];

   wire logic [2*NUM_REQ-1:0] levels = {
      pwm_fault_level, pwm_reload_level, adc_zero_cross_level, adc_b_done_level,
      adc_a_done_level, interval_timer2_level, interval_timer0_level,
      comparator_b_level, comparator_a_level, timer2_ch3_level, timer2_ch2_level,
      timer2_ch1_level, timer2_ch0_level};

   // Vector numbers rise with request index
   function automatic logic [5:0] vec_of(input int idx);
      return `IPVC_VEC_FIRST + 6'(idx);
   endfunction : vec_of

   // ****************************************************************
   // Arbitration
   // ****************************************************************
   logic [1:0] best_lvl;
   logic [5:0] best_num;
   logic [1:0] fast_hit;
   logic [1:0] lvl_i;

   // the code order is the level order, 00 never takes part
   // highest level, lower vector number on a tie
   always_comb begin
      best_lvl = `IPVC_LVL_OFF;
      best_num = 6'h00;
      fast_hit = 2'h0;
      lvl_i = `IPVC_LVL_OFF;
      for (int i = 0; i < NUM_REQ; i++) begin
         lvl_i = levels[2*i +: 2];
         if (REQ_I[i] && (lvl_i != `IPVC_LVL_OFF)) begin
            if ((lvl_i > best_lvl) || ((lvl_i == best_lvl) && (vec_of(i) < best_num))) begin
               best_lvl = lvl_i;
               best_num = vec_of(i);
            end
            // only a level 2 request is eligible for fast vectoring
            for (int k = 0; k < 2; k++) begin
               if ((lvl_i == `IPVC_LVL_2) && (fim_reg[k] == vec_of(i))) begin
                  fast_hit[k] = 1'b1;
               end
            end
         end
      end
   end

   wire logic sel_f = fast_hit[0] ? 1'b0 : 1'b1;
   wire logic take_fast = |fast_hit;
   wire logic [20:0] fast_addr = {fivah_reg[sel_f], fival_reg[sel_f]};
   // base on top, then the 6-bit winning vector number and a zero bit in the low 7 bits
   wire logic [20:0] table_addr = {vbase_reg, best_num, 1'b0};

   ipvc_vec_s out_next;
   always_comb begin
      out_next.irq = (best_lvl != `IPVC_LVL_OFF);
      out_next.fast = take_fast;
      out_next.level = best_lvl;
      // a fast request overrides the table winner
      out_next.num = take_fast ? fim_reg[sel_f] : best_num;
      out_next.addr = take_fast ? fast_addr : table_addr;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign IRQ_O = out_reg.irq;
   assign FAST_O = out_reg.fast;
   assign LEVEL_O = out_reg.level;
   assign VEC_NUM_O = out_reg.num;
   assign VECTOR_ADDR_O = out_reg.addr;

endmodule : ipvc_ctrl

// >>> rtl/ipvc_params.svh
// Register indices, field positions, masks and reset values of the vector controller
`ifndef IPVC_PARAMS_SVH
`define IPVC_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IPVC_IDX_TMR_CMP 4'h5
`define IPVC_IDX_PWM_ADC 4'h6
`define IPVC_IDX_VBASE 4'h7
`define IPVC_IDX_FAST_IRQ0_MATCH 4'h8
`define IPVC_IDX_FAST_IRQ0_ADDR_LOW 4'h9
`define IPVC_IDX_FAST_IRQ0_ADDR_HIGH 4'hA
`define IPVC_IDX_FIM1 4'hB
`define IPVC_IDX_FIVAL1 4'hC
`define IPVC_IDX_FIVAH1 4'hD

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define IPVC_MASK_TMR_CMP 16'hFFFF
`define IPVC_MASK_PWM_ADC 16'h0FFF
`define IPVC_MASK_VBASE 16'h3FFF
`define IPVC_MASK_FIM 16'h003F
`define IPVC_MASK_FIVAL 16'hFFFF
`define IPVC_MASK_FIVAH 16'h001F
`define IPVC_RST_LEVELS 16'h0000
`define IPVC_RST_FIM 16'h0000
`define IPVC_RST_FIVA 16'h0000
`define IPVC_VBASE_RST_DEFAULT 14'h0000

// ****************************************************************
// Level codes
// ****************************************************************
`define IPVC_LVL_OFF 2'h0
`define IPVC_LVL_2 2'h3

// ****************************************************************
// Field least significant bits
// ****************************************************************
`define IPVC_LSB_PIT0 12
`define IPVC_LSB_CMPB 10
`define IPVC_LSB_CMPA 8
`define IPVC_LSB_T2C3 6
`define IPVC_LSB_T2C2 4
`define IPVC_LSB_T2C1 2
`define IPVC_LSB_T2C0 0
`define IPVC_LSB_PWMF 10
`define IPVC_LSB_PWMR 8
`define IPVC_LSB_ADZC 6
`define IPVC_LSB_ADBD 4
`define IPVC_LSB_ADAD 2
`define IPVC_LSB_PIT2 0

// ****************************************************************
// Request vector numbers, in request index order
// ****************************************************************
`define IPVC_VEC_FIRST 6'h10

`endif

// >>> rtl/ipvc_pkg.sv
// Types shared by the vector controller
package ipvc_pkg;
   localparam int NUM_REQ = 13;

   typedef struct packed {
      logic irq;
      logic fast;
      logic [1:0] level;
      logic [5:0] num;
      logic [20:0] addr;
   } ipvc_vec_s;

   typedef logic [15:0] ipvc_word_t;
endpackage : ipvc_pkg

// >>> testbench/ipvc_core_model.sv
// Core side model that takes the presented vector
`timescale 1ns/100ps
module ipvc_core_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic irq_i,
   input wire logic [20:0] addr_i,
   output logic [20:0] addr_o
);
   // No request means no vector taken, so a stale address never lingers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) addr_o <= 21'h000000;
      else addr_o <= irq_i ? addr_i : 21'h000000;
   end
endmodule : ipvc_core_model

// >>> testbench/ipvc_ctrl_chk.sv
// Port assertions for the vector controller
`timescale 1ns/100ps
module ipvc_ctrl_chk
   import ipvc_pkg::*;
#(parameter logic [13:0] VBASE_RESET = 14'h0000, parameter int ADDR_W = 8) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [NUM_REQ-1:0] REQ_I,
   input wire logic IRQ_O,
   input wire logic FAST_O,
   input wire logic [1:0] LEVEL_O,
   input wire logic [5:0] VEC_NUM_O,
   input wire logic [20:0] VECTOR_ADDR_O
);
   logic [13:0] vb_reg;
   wire acc = PSEL_I && PENABLE_I;
   wire tbl = IRQ_O && !FAST_O;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) vb_reg <= VBASE_RESET;
      else if (acc && PWRITE_I && PADDR_I == 8'h1C) vb_reg <= PWDATA_I[13:0];
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   chk_ready_high: assert property (PREADY_O) else $error("ready low");
   chk_reset_quiet: assert property ($rose(RST_N_I) |-> !IRQ_O && VECTOR_ADDR_O == 21'h0)
      else $error("output active after reset");
   chk_level_none: assert property (!IRQ_O |-> LEVEL_O == 2'h0 && !FAST_O)
      else $error("level without request");
   chk_level_some: assert property (IRQ_O |-> LEVEL_O != 2'h0) else $error("request at off");
   chk_idle_req: assert property ($past(REQ_I) == '0 |-> !IRQ_O) else $error("spurious irq");
   chk_table_low: assert property (tbl |-> VECTOR_ADDR_O[6:0] == {VEC_NUM_O, 1'b0})
      else $error("low vector bits wrong");
   chk_table_base: assert property (tbl |-> VECTOR_ADDR_O[20:7] == $past(vb_reg))
      else $error("vector base bits wrong");
   chk_fast_top: assert property (FAST_O |-> IRQ_O && LEVEL_O == 2'h3)
      else $error("fast winner not top level");
   chk_rsvd_zero: assert property (acc && !PWRITE_I && PADDR_I == 8'h18 |-> PRDATA_O[31:12] == 0)
      else $error("reserved bits set");
   chk_bad_addr: assert property (acc && PADDR_I[1:0] != 2'h0 |-> PSLVERR_O)
      else $error("misaligned not refused");
   cover property (FAST_O);
   cover property (IRQ_O && LEVEL_O == 2'h1);
   cover property (PSLVERR_O);
endmodule : ipvc_ctrl_chk

// >>> testbench/irq_priority_vector_ctrl_test.sv
// Self-checking bench for the vector controller
`timescale 1ns/100ps
`include "ipvc_params.svh"
module irq_priority_vector_ctrl_test;
   import ipvc_pkg::*;
   localparam logic [13:0] VB = 14'h0080;
   logic clk, rst_n, psel, pen, pwr, pready, pslverr, irq, fast;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [12:0] req;
   logic [1:0] lvl;
   logic [5:0] vnum;
   logic [20:0] vaddr, core_addr;
   int n_errors, n_tests;
   ipvc_ctrl #(.VBASE_RESET(VB)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .REQ_I(req), .IRQ_O(irq), .FAST_O(fast),
      .LEVEL_O(lvl), .VEC_NUM_O(vnum), .VECTOR_ADDR_O(vaddr));
   ipvc_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .addr_i(vaddr),
      .addr_o(core_addr));
   function automatic logic [7:0] ba(input logic [3:0] i);
      return {2'h0, i, 2'h0};
   endfunction : ba
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata; e = pslverr;
      psel <= 1'b0; pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, ba(i), d, q, e);
   endtask : wr
   task automatic rd(input logic [3:0] i, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      apb(1'b0, ba(i), 32'h0, q, e);
      chk("register read", x, q);
   endtask : rd
   task automatic vec(input logic [12:0] r, input ipvc_vec_s e);
      @(posedge clk);
      req <= r;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("vector", {1'b0, e}, {1'b0, irq, fast, lvl, vnum, core_addr});
   endtask : vec
   task automatic t_regs();
      logic [3:0] ix[4] = '{4'h5, 4'h6, 4'h7, 4'h8};
      logic [15:0] m[4] = '{16'hFFFF, 16'h0FFF, 16'h3FFF, 16'h003F};
      logic [31:0] q;
      logic e;
      rd(4'h5, 32'h0);
      rd(4'h6, 32'h0);
      rd(4'h7, {18'h0, VB});
      rd(4'h8, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(ix[i], 32'hFFFFFFFF);
         rd(ix[i], {16'h0, m[i]});
         wr(ix[i], (i == 2) ? {18'h0, VB} : 32'h0);
      end
      apb(1'b0, 8'h0C, 32'h0, q, e);
      chk("unmapped read", 33'h0_0000_0001, {q, e});
      apb(1'b1, 8'h15, 32'h1, q, e);
      chk("misaligned error", 32'h1, {31'h0, e});
      $display("test registers done");
   endtask : t_regs
   task automatic t_fields();
      logic [1:0] c;
      logic [3:0] r;
      int l;
      vec(13'h1FFF, '0);
      for (int i = 0; i < 13; i++) begin
         c = 2'(i % 3 + 1);
         r = (i < 7) ? 4'h5 : 4'h6;
         l = (i < 7) ? 2 * i : 2 * (i - 7);
         wr(r, 32'(c) << l);
         vec(13'h1FFF, '{1'b1, 1'b0, c, 6'h10 + 6'(i), {VB, 6'h10 + 6'(i), 1'b0}});
         wr(r, 32'h0);
      end
      $display("test fields done");
   endtask : t_fields
   task automatic t_arb();
      wr(4'h5, 32'h000F);
      vec(13'h0003, '{1'b1, 1'b0, 2'h3, 6'h10, {VB, 7'h20}});
      wr(4'h5, 32'h000D);
      vec(13'h0003, '{1'b1, 1'b0, 2'h3, 6'h11, {VB, 7'h22}});
      $display("test arbitration done");
   endtask : t_arb
   task automatic t_fast();
      wr(4'h5, 32'h00C3);
      wr(4'h8, 32'h13);
      wr(4'h9, 32'h1234);
      wr(4'hA, 32'h15);
      wr(4'hB, 32'h10);
      wr(4'hC, 32'h5678);
      wr(4'hD, 32'h0A);
      vec(13'h0009, '{1'b1, 1'b1, 2'h3, 6'h13, {5'h15, 16'h1234}});
      vec(13'h0001, '{1'b1, 1'b1, 2'h3, 6'h10, {5'h0A, 16'h5678}});
      vec(13'h0000, '0);
      $display("test fast done");
   endtask : t_fast
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      test_done();
   end
   initial begin
      rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; req = 13'h0;
      n_errors = 0; n_tests = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_fields();
      t_arb();
      t_fast();
      test_done();
   end
endmodule : irq_priority_vector_ctrl_test
bind ipvc_ctrl ipvc_ctrl_chk #(.VBASE_RESET(VBASE_RESET), .ADDR_W(ADDR_W)) u_chk (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .REQ_I(REQ_I), .IRQ_O(IRQ_O), .FAST_O(FAST_O),
   .LEVEL_O(LEVEL_O), .VEC_NUM_O(VEC_NUM_O), .VECTOR_ADDR_O(VECTOR_ADDR_O));
